// ---- rtl/arc_role_cfg.sv ----
// Purpose: paged configuration bank for serial port roles and dynamic channel limits
// Assumes: control port requests are single-cycle strobes on sys_clk
// Notes: role select and max-channel choice come from neighbouring registers as inputs
`timescale 1ns/1ps
module arc_role_cfg #(
   parameter int FRAME_BITS = arc_pkg::ARC_FRAME_BITS
) (
   // system clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // control port
   input wire logic ctl_req,
   input wire logic ctl_write,
   input wire logic [7:0] ctl_addr,
   input wire logic [7:0] ctl_wdata,
   output logic [7:0] ctl_rdata,
   output logic ctl_ack,
   // settings from neighbouring registers
   input wire logic primary_role_select,
   input wire logic secondary_role_select,
   input wire logic [arc_pkg::ARC_CH_W-1:0] adc_max_channel_choice,
   input wire logic [arc_pkg::ARC_CH_W-1:0] dac_max_channel_choice,
   // role and channel results
   output logic primary_autodetect_on,
   output logic secondary_autodetect_on,
   output logic primary_internal_frame_sync,
   output logic secondary_internal_frame_sync,
   output logic [arc_pkg::ARC_CH_W-1:0] adc_active_channels,
   output logic [arc_pkg::ARC_CH_W-1:0] dac_active_channels,
   // link clock
   input wire logic link_clk,
   // primary serial port pins
   output logic primary_bit_clock_tx,
   output logic primary_bit_clock_oe,
   input wire logic primary_frame_sync_rx,
   output logic primary_frame_sync_tx,
   output logic primary_frame_sync_oe,
   output logic primary_frame_mark,
   // secondary serial port pins
   output logic secondary_bit_clock_tx,
   output logic secondary_bit_clock_oe,
   input wire logic secondary_frame_sync_rx,
   output logic secondary_frame_sync_tx,
   output logic secondary_frame_sync_oe,
   output logic secondary_frame_mark
);
   import arc_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] page;
      logic [7:0] clk_role;
      logic [7:0] adc_lim;
      logic [7:0] dac_lim;
      logic [7:0] rdata;
      logic ack;
      logic [3:0] p_role;
      logic [3:0] s_role;
      logic [ARC_CH_W-1:0] adc_mask;
      logic [ARC_CH_W-1:0] dac_mask;
   } arc_top_state_t;

   // role vector layout: bclk drive, fs drive, internal fs, autodetect
   localparam int RL_BCLK = 3;
   localparam int RL_FSOE = 2;
   localparam int RL_INT = 1;
   localparam int RL_AUTO = 0;

   localparam arc_top_state_t ARC_TOP_RST = '{
      page: ARC_RST_PAGE,
      clk_role: ARC_RST_CLK_ROLE,
      adc_lim: ARC_RST_LIMIT,
      dac_lim: ARC_RST_LIMIT,
      rdata: 8'h00,
      ack: 1'b0,
      p_role: 4'h0,
      s_role: 4'h0,
      adc_mask: '0,
      dac_mask: '0
   };

   arc_top_state_t st_reg;
   arc_top_state_t st_next;
   logic [7:0] rd_value;
   logic in_bank;

   // ----------------------------------------------------------------
   // role derivation for one port
   // ----------------------------------------------------------------
   // select high means controller; in split mode the bit clock follows the
   // select and the frame sync goes the other way
   function automatic logic [3:0] arc_port_role(input logic ovr, input logic sel,
                                                input logic use_int);
      logic [3:0] r;
      r = 4'h0;
      r[RL_BCLK] = sel;
      r[RL_FSOE] = ovr ? ~sel : sel;
      // an output frame sync in split mode has only the generator to use
      r[RL_INT] = ovr ? ~sel : (sel & use_int);
      r[RL_AUTO] = ~ovr;
      return r;
   endfunction

   function automatic logic [ARC_CH_W-1:0] arc_limit(input logic [7:0] reg_val,
                                                    input logic [ARC_CH_W-1:0] choice);
      // mask bit n is channel n+1, so the field maps straight across
      return reg_val[ARC_BIT_FORCE] ? reg_val[ARC_MASK_LSB +: ARC_CH_W] : choice;
   endfunction

   // ----------------------------------------------------------------
   // register access and derived outputs
   // ----------------------------------------------------------------
   always_comb begin
      in_bank = (st_reg.page == ARC_BANK_PAGE);
      rd_value = 8'h00;
      if (ctl_addr == ARC_OFF_PAGE) begin
         rd_value = st_reg.page;
      end else if (in_bank && ctl_addr == ARC_OFF_CLK_ROLE) begin
         rd_value = st_reg.clk_role;
      end else if (in_bank && ctl_addr == ARC_OFF_ADC_LIMIT) begin
         rd_value = st_reg.adc_lim;
      end else if (in_bank && ctl_addr == ARC_OFF_DAC_LIMIT) begin
         rd_value = st_reg.dac_lim;
      end

      st_next = st_reg;
      st_next.ack = ctl_req;
      if (ctl_req && ctl_write) begin
         // reserved bits are dropped on write and stay zero
         if (ctl_addr == ARC_OFF_PAGE) begin
            st_next.page = ctl_wdata;
         end else if (in_bank && ctl_addr == ARC_OFF_CLK_ROLE) begin
            st_next.clk_role = ctl_wdata & ARC_WMASK_CLK_ROLE;
         end else if (in_bank && ctl_addr == ARC_OFF_ADC_LIMIT) begin
            st_next.adc_lim = ctl_wdata & ARC_WMASK_LIMIT;
         end else if (in_bank && ctl_addr == ARC_OFF_DAC_LIMIT) begin
            st_next.dac_lim = ctl_wdata & ARC_WMASK_LIMIT;
         end
      end else if (ctl_req) begin
         st_next.rdata = rd_value;
      end

      st_next.p_role = arc_port_role(st_reg.clk_role[ARC_BIT_OVR_PRI], primary_role_select,
                                     st_reg.clk_role[ARC_BIT_INTFS_PRI]);
      st_next.s_role = arc_port_role(st_reg.clk_role[ARC_BIT_OVR_SEC], secondary_role_select,
                                     st_reg.clk_role[ARC_BIT_INTFS_SEC]);
      st_next.adc_mask = arc_limit(st_reg.adc_lim, adc_max_channel_choice);
      st_next.dac_mask = arc_limit(st_reg.dac_lim, dac_max_channel_choice);
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         st_reg <= ARC_TOP_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ctl_rdata = st_reg.rdata;
   assign ctl_ack = st_reg.ack;
   assign primary_autodetect_on = st_reg.p_role[RL_AUTO];
   assign secondary_autodetect_on = st_reg.s_role[RL_AUTO];
   assign primary_internal_frame_sync = st_reg.p_role[RL_INT];
   assign secondary_internal_frame_sync = st_reg.s_role[RL_INT];
   assign adc_active_channels = st_reg.adc_mask;
   assign dac_active_channels = st_reg.dac_mask;

   // ----------------------------------------------------------------
   // crossing into the link clock
   // ----------------------------------------------------------------
   // role bits are levels held by flops, the frame sync pins come straight in; the reset level rides
   // the same synchroniser so link logic leaves reset after sys reset
   logic [ARC_SYNC_W-1:0] sync_d;
   logic [ARC_SYNC_W-1:0] sync_q;

   always_comb begin
      sync_d = '0;
      sync_d[ARC_SY_RST] = reset_n;
      sync_d[ARC_SY_P_BCLK] = st_reg.p_role[RL_BCLK];
      sync_d[ARC_SY_P_FSOE] = st_reg.p_role[RL_FSOE];
      sync_d[ARC_SY_P_INT] = st_reg.p_role[RL_INT];
      sync_d[ARC_SY_S_BCLK] = st_reg.s_role[RL_BCLK];
      sync_d[ARC_SY_S_FSOE] = st_reg.s_role[RL_FSOE];
      sync_d[ARC_SY_S_INT] = st_reg.s_role[RL_INT];
      sync_d[ARC_SY_P_PIN] = primary_frame_sync_rx;
      sync_d[ARC_SY_S_PIN] = secondary_frame_sync_rx;
   end

   arc_sync #(.W(ARC_SYNC_W)) u_sync (
      .clk(link_clk),
      .d(sync_d),
      .q(sync_q)
   );

   arc_link #(.FRAME_BITS(FRAME_BITS)) u_primary (
      .link_clk(link_clk),
      .link_rst_n(sync_q[ARC_SY_RST]),
      .bit_clock_drive(sync_q[ARC_SY_P_BCLK]),
      .frame_sync_drive(sync_q[ARC_SY_P_FSOE]),
      .use_internal(sync_q[ARC_SY_P_INT]),
      .frame_sync_rx(sync_q[ARC_SY_P_PIN]),
      .bit_clock_tx(primary_bit_clock_tx),
      .bit_clock_oe(primary_bit_clock_oe),
      .frame_sync_tx(primary_frame_sync_tx),
      .frame_sync_oe(primary_frame_sync_oe),
      .frame_mark(primary_frame_mark)
   );

   arc_link #(.FRAME_BITS(FRAME_BITS)) u_secondary (
      .link_clk(link_clk),
      .link_rst_n(sync_q[ARC_SY_RST]),
      .bit_clock_drive(sync_q[ARC_SY_S_BCLK]),
      .frame_sync_drive(sync_q[ARC_SY_S_FSOE]),
      .use_internal(sync_q[ARC_SY_S_INT]),
      .frame_sync_rx(sync_q[ARC_SY_S_PIN]),
      .bit_clock_tx(secondary_bit_clock_tx),
      .bit_clock_oe(secondary_bit_clock_oe),
      .frame_sync_tx(secondary_frame_sync_tx),
      .frame_sync_oe(secondary_frame_sync_oe),
      .frame_mark(secondary_frame_mark)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking arc_cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   chk_primary_plain_role: assert property (
      !st_reg.clk_role[ARC_BIT_OVR_PRI] |=>
         st_reg.p_role[RL_FSOE] == $past(primary_role_select) &&
         st_reg.p_role[RL_BCLK] == st_reg.p_role[RL_FSOE])
      else $error("primary role does not follow its select");

   chk_secondary_plain_role: assert property (
      !st_reg.clk_role[ARC_BIT_OVR_SEC] |=>
         st_reg.s_role[RL_FSOE] == $past(secondary_role_select) &&
         st_reg.s_role[RL_BCLK] == st_reg.s_role[RL_FSOE])
      else $error("secondary role does not follow its select");

   chk_split_fs_out: assert property (
      st_reg.clk_role[ARC_BIT_OVR_PRI] && !primary_role_select |=>
         !st_reg.p_role[RL_BCLK] && st_reg.p_role[RL_FSOE])
      else $error("split mode with select low has wrong directions");

   chk_split_bclk_out: assert property (
      st_reg.clk_role[ARC_BIT_OVR_SEC] && secondary_role_select |=>
         st_reg.s_role[RL_BCLK] && !st_reg.s_role[RL_FSOE])
      else $error("split mode with select high has wrong directions");

   chk_autodetect_off: assert property (
      st_reg.clk_role[ARC_BIT_OVR_PRI] |=> !st_reg.p_role[RL_AUTO])
      else $error("auto detection left on under override");

   chk_primary_fs_src: assert property (
      !st_reg.clk_role[ARC_BIT_OVR_PRI] && primary_role_select |=>
         st_reg.p_role[RL_INT] == $past(st_reg.clk_role[ARC_BIT_INTFS_PRI]))
      else $error("primary frame sync source wrong");

   chk_secondary_fs_src: assert property (
      !st_reg.clk_role[ARC_BIT_OVR_SEC] && secondary_role_select |=>
         st_reg.s_role[RL_INT] == $past(st_reg.clk_role[ARC_BIT_INTFS_SEC]))
      else $error("secondary frame sync source wrong");

   chk_adc_limit_sel: assert property (
      ##1 st_reg.adc_mask == ($past(st_reg.adc_lim[ARC_BIT_FORCE]) ?
         $past(st_reg.adc_lim[ARC_MASK_LSB +: ARC_CH_W]) : $past(adc_max_channel_choice)))
      else $error("ADC channel limit picked from wrong source");

   chk_dac_limit_sel: assert property (
      ctl_req && ctl_write && st_reg.page == ARC_BANK_PAGE &&
         ctl_addr == ARC_OFF_DAC_LIMIT && ctl_wdata[ARC_BIT_FORCE] |=>
         ##1 st_reg.dac_mask == $past(ctl_wdata[ARC_MASK_LSB +: ARC_CH_W], 2))
      else $error("DAC custom mask not applied two cycles after write");

   chk_page_gates: assert property (
      ctl_req && ctl_write && st_reg.page != ARC_BANK_PAGE &&
         ctl_addr != ARC_OFF_PAGE |=> $stable(st_reg.clk_role) &&
         $stable(st_reg.adc_lim) && $stable(st_reg.dac_lim))
      else $error("write on another page changed the bank");

   chk_reserved_zero: assert property (
      ctl_req && !ctl_write && st_reg.page == ARC_BANK_PAGE &&
         ctl_addr == ARC_OFF_CLK_ROLE |=>
         ctl_ack && (ctl_rdata & ~ARC_WMASK_CLK_ROLE) == 8'h00)
      else $error("reserved bits read nonzero");

   cov_split_primary: cover property (
      st_reg.clk_role[ARC_BIT_OVR_PRI] && !primary_role_select ##1 st_reg.p_role[RL_FSOE]);
   cov_adc_custom: cover property (st_reg.adc_lim[ARC_BIT_FORCE] ##1 st_reg.adc_mask != 4'h0);
   cov_page_move: cover property (
      ctl_req && ctl_write && ctl_addr == ARC_OFF_PAGE && ctl_wdata != ARC_BANK_PAGE);
endmodule

// ---- rtl/arc_pkg.sv ----
// Purpose: shared constants for the serial port role and dynamic channel configuration bank
// Assumes: 8-bit paged control port, page register at offset zero on every page
package arc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ARC_OFF_PAGE = 8'h00;
   localparam logic [7:0] ARC_OFF_CLK_ROLE = 8'h0d;
   localparam logic [7:0] ARC_OFF_ADC_LIMIT = 8'h0e;
   localparam logic [7:0] ARC_OFF_DAC_LIMIT = 8'h0f;
   localparam logic [7:0] ARC_BANK_PAGE = 8'h00;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int ARC_BIT_OVR_PRI = 7;
   localparam int ARC_BIT_OVR_SEC = 6;
   localparam int ARC_BIT_INTFS_PRI = 2;
   localparam int ARC_BIT_INTFS_SEC = 1;
   localparam int ARC_BIT_FORCE = 7;
   localparam int ARC_MASK_LSB = 3;
   localparam int ARC_CH_W = 4;
   localparam logic [7:0] ARC_WMASK_CLK_ROLE = 8'hc6;
   localparam logic [7:0] ARC_WMASK_LIMIT = 8'hf8;
   localparam logic [7:0] ARC_RST_PAGE = 8'h00;
   localparam logic [7:0] ARC_RST_CLK_ROLE = 8'h00;
   localparam logic [7:0] ARC_RST_LIMIT = 8'h00;

   // ----------------------------------------------------------------
   // link side
   // ----------------------------------------------------------------
   localparam int ARC_FRAME_BITS = 64;
   localparam int ARC_SYNC_W = 9;
   localparam int ARC_SY_RST = 0;
   localparam int ARC_SY_P_BCLK = 1;
   localparam int ARC_SY_P_FSOE = 2;
   localparam int ARC_SY_P_INT = 3;
   localparam int ARC_SY_S_BCLK = 4;
   localparam int ARC_SY_S_FSOE = 5;
   localparam int ARC_SY_S_INT = 6;
   localparam int ARC_SY_P_PIN = 7;
   localparam int ARC_SY_S_PIN = 8;

endpackage

// ---- rtl/arc_sync.sv ----
// Purpose: two-flop level synchroniser, one bit per lane
// Assumes: inputs are slow levels relative to clk
// Notes: no reset, so it may also carry a reset level into the clock domain
`timescale 1ns/1ps
module arc_sync #(
   parameter int W = 1
) (
   // clock
   input wire logic clk,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } arc_sync_state_t;

   arc_sync_state_t st_reg;
   arc_sync_state_t st_next;

   // first stage feeds only the second stage
   always_comb begin
      st_next = st_reg;
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end

   assign q = st_reg.s2;
endmodule

// ---- rtl/arc_link.sv ----
// Purpose: one serial port's pin drivers and frame sync selection on the link clock
// Assumes: all inputs already synchronised to link_clk
// Notes: the internal frame sync is a one-bit pulse every FRAME_BITS link clocks
`timescale 1ns/1ps
module arc_link #(
   parameter int FRAME_BITS = arc_pkg::ARC_FRAME_BITS
) (
   // clock and reset
   input wire logic link_clk,
   input wire logic link_rst_n,
   // configuration
   input wire logic bit_clock_drive,
   input wire logic frame_sync_drive,
   input wire logic use_internal,
   input wire logic frame_sync_rx,
   // pins and framing
   output logic bit_clock_tx,
   output logic bit_clock_oe,
   output logic frame_sync_tx,
   output logic frame_sync_oe,
   output logic frame_mark
);
   import arc_pkg::*;

   localparam int CW = (FRAME_BITS > 1) ? $clog2(FRAME_BITS) : 1;
   localparam logic [CW-1:0] CNT_LAST = CW'(FRAME_BITS - 1);

   typedef struct packed {
      logic bclk;
      logic bclk_oe;
      logic fs;
      logic fs_oe;
      logic mark;
      logic [CW-1:0] cnt;
   } arc_link_state_t;

   arc_link_state_t st_reg;
   arc_link_state_t st_next;
   logic int_pulse;

   always_comb begin
      int_pulse = (st_reg.cnt == '0);
      st_next = st_reg;
      st_next.cnt = (st_reg.cnt == CNT_LAST) ? '0 : st_reg.cnt + 1'b1;
      st_next.bclk = bit_clock_drive & ~st_reg.bclk;
      st_next.bclk_oe = bit_clock_drive;
      st_next.fs_oe = frame_sync_drive;
      st_next.fs = frame_sync_drive & int_pulse;
      // framing reference: generator or the pin, per the source select
      st_next.mark = use_internal ? int_pulse : frame_sync_rx;
   end

   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign bit_clock_tx = st_reg.bclk;
   assign bit_clock_oe = st_reg.bclk_oe;
   assign frame_sync_tx = st_reg.fs;
   assign frame_sync_oe = st_reg.fs_oe;
   assign frame_mark = st_reg.mark;

   chk_link_fs_idle: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      !st_reg.fs_oe |-> !st_reg.fs)
      else $error("frame sync toggles while not driven");
endmodule

// ---- testbench/arc_far_end.sv ----
// Purpose: far side of one serial port, supplying frame sync when the device does not drive it
// Assumes: frame sync wire is shared by the device and this model
// Notes: pulse every 8 link clocks; no pull on the wire, so the active driver wins
`timescale 1ns/1ps
module arc_far_end (
   // link clock
   input wire logic link_clk,
   // device side of the wire
   input wire logic fs_oe,
   input wire logic fs_tx,
   // wire level seen by the device
   output logic fs_rx
);
   logic [2:0] cnt_reg = 3'h0;
   logic pulse_reg = 1'b0;
   always_ff @(posedge link_clk) begin
      cnt_reg <= cnt_reg + 3'h1;
      // the far side only supplies frame sync while the device listens
      pulse_reg <= (cnt_reg == 3'h0) && !fs_oe;
   end
   assign fs_rx = fs_oe ? fs_tx : pulse_reg;
endmodule

// ---- testbench/asi_role_and_dyn_channel_cfg_tb.sv ----
// Purpose: self-checking bench for the role and dynamic channel configuration bank
// Assumes: single-cycle control port strobes, ack one cycle later
// Notes: random register contents with page and unmapped corner cases
`timescale 1ns/1ps
module asi_role_and_dyn_channel_cfg_tb;
   import arc_pkg::*;
   logic sys_clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0;
   logic ctl_req = 1'b0, ctl_write = 1'b0, ctl_ack;
   logic [7:0] ctl_addr = 8'h00, ctl_wdata = 8'h00, ctl_rdata, rd;
   logic [1:0] sel = 2'h0, auto_o, intl_o, bco, fso, fstx, fsrx, mark, bctx;
   logic [3:0] adc_ch = 4'h0, dac_ch = 4'h0, adc_o, dac_o;
   logic [7:0] r_role, r_adc, r_dac;
   int num_errors = 0, num_checks = 0;
   int fs_cnt[2], bc_cnt[2], mk_cnt[2], co_cnt[2];
   logic [1:0] bc_last;
   initial forever #12.5 sys_clk = ~sys_clk;
   // small start offset keeps the link clock out of phase with sys_clk
   initial begin
      #5;
      forever #32 link_clk = ~link_clk;
   end
   arc_role_cfg #(.FRAME_BITS(4)) dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .ctl_req(ctl_req), .ctl_write(ctl_write),
      .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .ctl_ack(ctl_ack),
      .primary_role_select(sel[0]), .secondary_role_select(sel[1]),
      .adc_max_channel_choice(adc_ch), .dac_max_channel_choice(dac_ch),
      .primary_autodetect_on(auto_o[0]), .secondary_autodetect_on(auto_o[1]),
      .primary_internal_frame_sync(intl_o[0]), .secondary_internal_frame_sync(intl_o[1]),
      .adc_active_channels(adc_o), .dac_active_channels(dac_o), .link_clk(link_clk),
      .primary_bit_clock_tx(bctx[0]), .primary_bit_clock_oe(bco[0]),
      .primary_frame_sync_rx(fsrx[0]), .primary_frame_sync_tx(fstx[0]),
      .primary_frame_sync_oe(fso[0]), .primary_frame_mark(mark[0]),
      .secondary_bit_clock_tx(bctx[1]), .secondary_bit_clock_oe(bco[1]),
      .secondary_frame_sync_rx(fsrx[1]), .secondary_frame_sync_tx(fstx[1]),
      .secondary_frame_sync_oe(fso[1]), .secondary_frame_mark(mark[1]));
   arc_far_end far_p (.link_clk(link_clk), .fs_oe(fso[0]), .fs_tx(fstx[0]), .fs_rx(fsrx[0]));
   arc_far_end far_s (.link_clk(link_clk), .fs_oe(fso[1]), .fs_tx(fstx[1]), .fs_rx(fsrx[1]));
   // ----------------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------------
   task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      #2;
      ctl_req = 1'b1;
      ctl_write = wr;
      ctl_addr = addr;
      ctl_wdata = data;
      @(posedge sys_clk);
      #2;
      ctl_req = 1'b0;
      compare("ack", 8'h01, {7'h0, ctl_ack});
      rd = ctl_rdata;
   endtask
   task automatic read_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
      access(1'b0, addr, 8'h00);
      compare(what, exp, rd);
   endtask
   function automatic logic [3:0] role_exp(input logic ovr, input logic s, input logic fs);
      // {autodetect, internal, bit clock oe, frame sync oe}
      return {~ovr, ovr ? ~s : s & fs, s, ovr ? ~s : s};
   endfunction
   task automatic results();
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      #1_500_000;
      num_errors++;
      results();
   end
   initial begin
      logic [3:0] e;
      void'($urandom(32'hb45f));
      repeat (4) @(posedge sys_clk);
      #2;
      reset_n = 1'b1;
      read_chk("role reset", ARC_OFF_CLK_ROLE, 8'h00);
      read_chk("adc reset", ARC_OFF_ADC_LIMIT, 8'h00);
      read_chk("dac reset", ARC_OFF_DAC_LIMIT, 8'h00);
      for (int i = 0; i < 24; i++) begin
         // host keeps reserved bits at zero
         r_role = 8'($urandom) & ARC_WMASK_CLK_ROLE;
         r_adc = 8'($urandom) & ARC_WMASK_LIMIT;
         r_dac = 8'($urandom) & ARC_WMASK_LIMIT;
         sel = 2'($urandom);
         adc_ch = 4'($urandom);
         dac_ch = 4'($urandom);
         access(1'b1, ARC_OFF_CLK_ROLE, r_role);
         access(1'b1, ARC_OFF_ADC_LIMIT, r_adc);
         access(1'b1, ARC_OFF_DAC_LIMIT, r_dac);
         read_chk("role", ARC_OFF_CLK_ROLE, r_role);
         read_chk("adc", ARC_OFF_ADC_LIMIT, r_adc);
         read_chk("dac", ARC_OFF_DAC_LIMIT, r_dac);
         compare("adc ch", {4'h0, r_adc[7] ? r_adc[6:3] : adc_ch}, {4'h0, adc_o});
         compare("dac ch", {4'h0, r_dac[7] ? r_dac[6:3] : dac_ch}, {4'h0, dac_o});
         repeat (10) @(posedge link_clk);
         fs_cnt = '{0, 0};
         bc_cnt = '{0, 0};
         mk_cnt = '{0, 0};
         co_cnt = '{0, 0};
         bc_last = bctx;
         repeat (24) begin
            @(posedge link_clk);
            #1;
            for (int p = 0; p < 2; p++) begin
               fs_cnt[p] += int'(fstx[p]);
               bc_cnt[p] += int'(bctx[p] != bc_last[p]);
               mk_cnt[p] += int'(mark[p]);
               // generator marks line up with our own pulses; pin marks lag by the sync
               co_cnt[p] += int'(mark[p] && fstx[p]);
            end
            bc_last = bctx;
         end
         for (int p = 0; p < 2; p++) begin
            e = role_exp(r_role[ARC_BIT_OVR_PRI - p], sel[p], r_role[ARC_BIT_INTFS_PRI - p]);
            compare("autodetect", {7'h0, e[3]}, {7'h0, auto_o[p]});
            compare("internal", {7'h0, e[2]}, {7'h0, intl_o[p]});
            compare("bclk oe", {7'h0, e[1]}, {7'h0, bco[p]});
            compare("fs oe", {7'h0, e[0]}, {7'h0, fso[p]});
            compare("fs pulses", {7'h0, e[0]}, {7'h0, fs_cnt[p] > 0});
            compare("bclk toggles", {7'h0, e[1]}, {7'h0, bc_cnt[p] > 0});
            compare("frame marks", e[0] ? 8'h06 : 8'h03, 8'(mk_cnt[p]));
            compare("internal marks", e[2] ? 8'h06 : 8'h00, 8'(co_cnt[p]));
         end
      end
      access(1'b1, ARC_OFF_PAGE, 8'hff);
      read_chk("page", ARC_OFF_PAGE, 8'hff);
      access(1'b1, ARC_OFF_CLK_ROLE, ARC_WMASK_CLK_ROLE ^ r_role);
      read_chk("off page", ARC_OFF_CLK_ROLE, 8'h00);
      access(1'b1, ARC_OFF_PAGE, 8'h00);
      read_chk("back on page", ARC_OFF_CLK_ROLE, r_role);
      read_chk("unmapped", 8'h05, 8'h00);
      results();
   end
endmodule
